// ---- t1_rx_pkg.sv ----
// Functional notes
// R1: violation counter 8 bits, saturates, interrupts after.
// R2: violation counter presettable, readable, counts during resync.
// R3: B8ZS code word violations are not counted.
// R4: two 4-bit error counters, saturate, then interrupt.
// R5: both error counters share one byte address.
// R6: frame-loss counter; second counter follows framing mode.
// R7: error counters frozen while loss of sync high.
// R8: loss of sync high during resync; status latched.
// R9: auto mode: resync on frame loss or carrier loss.
// R10: manual mode: resync only on control edge, reset.
// R11: yellow output follows alarm; 24-frame uses link pattern.
// R12: 12-frame yellow: 256 zero bit-2s or S-bit.
// R13: violation output one bit time, not B8ZS codes.
// R14: framing bit error gives two-bit frame error pulse.
// R15: CRC error gives one-bit pulse before multiframe sync.
// R16: carrier loss on 32nd zero, cleared by one.
// R17: reset clears registers, forces resync on release.
// R18: system holds reset at power-up, host rewrites controls.
// R19: serial select low: hardware mode, registers cleared.
// R20: five pins drive five control bits.
// R21: both suppression pins high: loopback, keep modes.
// R22: hardware mode: robbed bit on, bit-2 yellow, rest cleared.
package t1_rx_pkg;
  localparam logic [2:0] ADDR_BVC = 3'h0;
  localparam logic [2:0] ADDR_ECR = 3'h1;
  localparam logic [2:0] ADDR_MASK = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_CCR = 3'h4;
  localparam logic [2:0] ADDR_TCR = 3'h5;
  localparam logic [2:0] ADDR_RCR = 3'h6;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CCR_LOOP = 0;
  localparam int CCR_ZS = 1;
  localparam int CCR_B8ZS = 2;
  localparam int CCR_YFMT = 3;
  localparam int CCR_FRAME24 = 4;
  localparam int TCR_TXYEL = 0;
  localparam int TCR_SBIT_EXT = 2;
  localparam int TCR_RBS = 4;
  localparam int RCR_RESYNC = 0;
  localparam int RCR_MANUAL = 1;
  localparam int RCR_FS_COUNT = 3;
  localparam int ST_BVCS = 7;
  localparam int ST_ECS = 6;
  localparam int ST_YELLOW_ALARM_OUT = 5;
  localparam int ST_RCL = 4;
  localparam int ST_FERR = 3;
  localparam int ST_LOSS_OF_SYNC_OUT = 0;
  localparam int PIN_SBIT = 0;
  localparam int PIN_FRAME = 1;
  localparam int PIN_TXYEL = 2;
  localparam int PIN_ZS = 3;
  localparam int PIN_B8ZS = 4;
  localparam int PIN_SPS = 5;
  localparam logic [5:0] PIN_RESET = 6'h20;
  localparam logic [4:0] CL_LAST = 5'h1f;
  localparam logic [8:0] YEL_SETS = 9'h010;
  localparam logic [8:0] YEL_CHANNELS = 9'h100;
  localparam logic [15:0] YEL_PATTERN = 16'h00ff;
  localparam logic [3:0] LINK_LAST = 4'hf;
  localparam logic [1:0] FERR_HOLD = 2'h2;
  localparam logic [1:0] CRC_HOLD = 2'h1;

  typedef struct packed {
    logic bit_time;
    logic bit_one;
    logic bpv;
    logic b8zs_word;
    logic fbit_time;
    logic fbit_is_fs;
    logic fbit_err;
    logic crc_err;
    logic sync_found;
    logic link_time;
    logic link_bit;
    logic bit2_time;
    logic bit2;
    logic sbit12_time;
    logic sbit;
  } line_event_type;
endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_stable;

  // a bit changes only once stages two and three agree
  always_comb
  begin
    next_stable = stable;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (stage2[i] == stage3[i])
        next_stable[i] = stage3[i];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      stable <= RESET_VALUE;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      stable <= next_stable;
    end
  end
endmodule

// ---- sat_counter.sv ----
`timescale 1ns/1ps
module sat_counter #(
  parameter int WIDTH = 8
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic inc,
  output logic [WIDTH-1:0] count,
  output logic overflow
);
  localparam logic [WIDTH-1:0] MAX = '1;
  logic [WIDTH-1:0] next_count;
  logic next_overflow;

  always_comb
  begin
    next_count = count;
    next_overflow = 1'b0;
    if (clear)
      next_count = '0;
    else if (load)
      next_count = load_value; // [R2]
    else if (inc && count != MAX)
      next_count = count + 1'b1; // [R1]
    else if (inc)
      next_overflow = 1'b1; // [R1]
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      overflow <= 1'b0;
    end
    else
    begin
      count <= next_count;
      overflow <= next_overflow;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_SAT_HOLD: assert property ( // [R1]
    count == MAX && inc && !load && !clear |=> count == MAX && overflow)
    else $error("saturated counter moved or missed overflow");
  AST_PRESET: assert property ( // [R2]
    load && !clear |=> count == $past(load_value))
    else $error("preset value not taken");
  AST_COUNT_UP: assert property ( // [R2]
    inc && !load && !clear && count != MAX |=> count == $past(count) + 1'b1)
    else $error("counter did not step by one");
endmodule

// ---- t1_rx_monitor.sv ----
`timescale 1ns/1ps
module t1_rx_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serial_port_select,
  input wire logic [4:0] mode_pins,
  input wire t1_rx_pkg::line_event_type line,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [7:0] common_control,
  output logic [7:0] transmit_control,
  output logic loss_of_sync_out,
  output logic yellow_alarm_out,
  output logic bipolar_violation_out,
  output logic frame_error_out,
  output logic carrier_loss,
  output logic count_irq
);
  logic [5:0] pins;
  logic hw_mode, next_irq, bv_ovf, oof_ovf, esf_ovf, bv_load, ecr_load;
  logic bv_inc, oof_inc, esf_inc, oof_event, ft_err, resync_start;
  logic resync_pending, rcr0_prev, next_los, next_yel, next_bpv;
  logic next_ferr_out, next_cl;
  logic [7:0] receive_control, receive_irq_mask, receive_status;
  logic [7:0] next_rdata, next_ccr, next_tcr, next_rcr, next_mask;
  logic [7:0] next_status, bipolar_violation_count;
  logic [3:0] oof_count, esf_count, link_phase, next_link_phase;
  logic [2:0] fhist, next_fhist;
  logic [4:0] zero_run, next_zero_run;
  logic [8:0] yel_count, next_yel_count;
  logic [15:0] link_sr, next_link_sr;
  logic [1:0] ferr_cnt, next_ferr_cnt;

  function automatic logic reg_hit(input logic [2:0] addr);
    reg_hit = reg_addr == addr;
  endfunction

  pin_sync #(.WIDTH(6), .RESET_VALUE(t1_rx_pkg::PIN_RESET)) u_pins (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .async_in({serial_port_select, mode_pins}), .stable(pins)
  );

  assign hw_mode = !pins[t1_rx_pkg::PIN_SPS]; // [R19]
  assign bv_load = !hw_mode && reg_wr_en && reg_hit(t1_rx_pkg::ADDR_BVC);
  assign ecr_load = !hw_mode && reg_wr_en && reg_hit(t1_rx_pkg::ADDR_ECR);
  // replacement code violations are suppressed when B8ZS is on
  assign bv_inc = line.bpv && // [R2]
    !(common_control[t1_rx_pkg::CCR_B8ZS] && line.b8zs_word); // [R3]
  // two errors within four terminal framing bits; pattern bits are skipped
  assign ft_err = line.fbit_time && !line.fbit_is_fs && line.fbit_err;
  assign oof_event = ft_err && fhist != 3'h0; // [R9]
  assign oof_inc = oof_event && !loss_of_sync_out; // [R6] [R7]
  assign esf_inc = !loss_of_sync_out && // [R7]
    (common_control[t1_rx_pkg::CCR_FRAME24] ? oof_event || line.crc_err :
    line.fbit_time && line.fbit_err && (!line.fbit_is_fs ||
    receive_control[t1_rx_pkg::RCR_FS_COUNT])); // [R6]
  // auto mode resyncs on frame loss or carrier loss; manual mode
  // only on a rising control bit or the reset release
  assign resync_start = resync_pending || // [R17]
    (!receive_control[t1_rx_pkg::RCR_MANUAL] &&
      (oof_event || carrier_loss)) || // [R9]
    (receive_control[t1_rx_pkg::RCR_MANUAL] &&
      receive_control[t1_rx_pkg::RCR_RESYNC] && !rcr0_prev); // [R10]

  sat_counter #(.WIDTH(8)) u_bv (
    .ref_clk(ref_clk), .rst_n(rst_n), .clear(hw_mode), .load(bv_load),
    .load_value(reg_wdata), .inc(bv_inc),
    .count(bipolar_violation_count), .overflow(bv_ovf)
  );

  // both halves load from one byte write [R5]
  sat_counter #(.WIDTH(4)) u_oof (
    .ref_clk(ref_clk), .rst_n(rst_n), .clear(hw_mode), .load(ecr_load),
    .load_value(reg_wdata[7:4]), .inc(oof_inc),
    .count(oof_count), .overflow(oof_ovf)
  );

  sat_counter #(.WIDTH(4)) u_esf (
    .ref_clk(ref_clk), .rst_n(rst_n), .clear(hw_mode), .load(ecr_load),
    .load_value(reg_wdata[3:0]), .inc(esf_inc),
    .count(esf_count), .overflow(esf_ovf)
  );

  always_comb
  begin
    next_ccr = common_control;
    next_tcr = transmit_control;
    next_rcr = receive_control;
    next_mask = receive_irq_mask;
    next_status = receive_status;
    if (hw_mode)
    begin
      next_rcr = t1_rx_pkg::REG_RESET; // [R22]
      next_mask = t1_rx_pkg::REG_RESET; // [R19]
      next_status = t1_rx_pkg::REG_RESET;
      next_tcr = t1_rx_pkg::REG_RESET; // [R22]
      next_tcr[t1_rx_pkg::TCR_SBIT_EXT] = pins[t1_rx_pkg::PIN_SBIT]; // [R20]
      next_tcr[t1_rx_pkg::TCR_TXYEL] = pins[t1_rx_pkg::PIN_TXYEL]; // [R20]
      next_tcr[t1_rx_pkg::TCR_RBS] = 1'b1; // [R22]
      next_ccr = t1_rx_pkg::REG_RESET; // [R22]
      next_ccr[t1_rx_pkg::CCR_FRAME24] = pins[t1_rx_pkg::PIN_FRAME]; // [R20]
      if (pins[t1_rx_pkg::PIN_ZS] && pins[t1_rx_pkg::PIN_B8ZS])
      begin
        // keep the last suppression mode while looped back
        next_ccr[t1_rx_pkg::CCR_LOOP] = 1'b1; // [R21]
        next_ccr[t1_rx_pkg::CCR_ZS] = common_control[t1_rx_pkg::CCR_ZS];
        next_ccr[t1_rx_pkg::CCR_B8ZS] =
          common_control[t1_rx_pkg::CCR_B8ZS]; // [R21]
      end
      else
      begin
        next_ccr[t1_rx_pkg::CCR_ZS] = pins[t1_rx_pkg::PIN_ZS]; // [R20]
        next_ccr[t1_rx_pkg::CCR_B8ZS] = pins[t1_rx_pkg::PIN_B8ZS]; // [R20]
      end
    end
    else
    begin
      if (reg_wr_en && reg_hit(t1_rx_pkg::ADDR_CCR))
        next_ccr = reg_wdata;
      if (reg_wr_en && reg_hit(t1_rx_pkg::ADDR_TCR))
        next_tcr = reg_wdata;
      if (reg_wr_en && reg_hit(t1_rx_pkg::ADDR_RCR))
        next_rcr = reg_wdata;
      if (reg_wr_en && reg_hit(t1_rx_pkg::ADDR_MASK))
        next_mask = reg_wdata;
      if (reg_rd_en && reg_hit(t1_rx_pkg::ADDR_STATUS))
      begin
        next_status[t1_rx_pkg::ST_LOSS_OF_SYNC_OUT] = 1'b0;
        next_status[t1_rx_pkg::ST_YELLOW_ALARM_OUT] = 1'b0;
        next_status[t1_rx_pkg::ST_RCL] = 1'b0;
        next_status[t1_rx_pkg::ST_FERR] = 1'b0;
      end
      // saturation flags drop only on a preset below all ones
      if (bv_load && reg_wdata != 8'hff)
        next_status[t1_rx_pkg::ST_BVCS] = 1'b0;
      if (ecr_load && reg_wdata[7:4] != 4'hf && reg_wdata[3:0] != 4'hf)
        next_status[t1_rx_pkg::ST_ECS] = 1'b0;
    end
    // a live event wins over the read clear
    next_status[t1_rx_pkg::ST_LOSS_OF_SYNC_OUT] =
      next_status[t1_rx_pkg::ST_LOSS_OF_SYNC_OUT] | loss_of_sync_out; // [R8]
    next_status[t1_rx_pkg::ST_YELLOW_ALARM_OUT] =
      next_status[t1_rx_pkg::ST_YELLOW_ALARM_OUT] | yellow_alarm_out; // [R11]
    next_status[t1_rx_pkg::ST_RCL] =
      next_status[t1_rx_pkg::ST_RCL] | carrier_loss;
    next_status[t1_rx_pkg::ST_FERR] =
      next_status[t1_rx_pkg::ST_FERR] | frame_error_out;
    next_status[t1_rx_pkg::ST_BVCS] =
      next_status[t1_rx_pkg::ST_BVCS] | bv_ovf; // [R1]
    next_status[t1_rx_pkg::ST_ECS] =
      next_status[t1_rx_pkg::ST_ECS] | oof_ovf | esf_ovf; // [R4]
    next_irq = (bv_ovf && receive_irq_mask[t1_rx_pkg::ST_BVCS]) || // [R1]
      ((oof_ovf || esf_ovf) && receive_irq_mask[t1_rx_pkg::ST_ECS]); // [R4]
    next_rdata = 8'h00;
    unique case (reg_addr)
      t1_rx_pkg::ADDR_BVC: next_rdata = bipolar_violation_count; // [R2]
      t1_rx_pkg::ADDR_ECR: next_rdata = {oof_count, esf_count}; // [R5]
      t1_rx_pkg::ADDR_MASK: next_rdata = receive_irq_mask;
      t1_rx_pkg::ADDR_STATUS: next_rdata = receive_status;
      t1_rx_pkg::ADDR_CCR: next_rdata = common_control;
      t1_rx_pkg::ADDR_TCR: next_rdata = transmit_control;
      t1_rx_pkg::ADDR_RCR: next_rdata = receive_control;
      default: next_rdata = 8'h00;
    endcase
    if (!reg_rd_en)
      next_rdata = reg_rdata;
    next_los = loss_of_sync_out;
    if (resync_start)
      next_los = 1'b1; // [R8]
    else if (line.sync_found)
      next_los = 1'b0; // [R8]
    next_fhist = fhist;
    if (line.fbit_time && !line.fbit_is_fs)
      next_fhist = {fhist[1:0], line.fbit_err}; // [R9]
    next_bpv = bv_inc; // [R13]
    next_zero_run = zero_run;
    next_cl = carrier_loss;
    if (line.bit_time && line.bit_one)
    begin
      next_zero_run = 5'h00;
      next_cl = 1'b0; // [R16]
    end
    else if (line.bit_time && zero_run == t1_rx_pkg::CL_LAST)
      next_cl = 1'b1; // [R16]
    else if (line.bit_time)
      next_zero_run = zero_run + 5'h01;
    next_ferr_cnt = ferr_cnt;
    if (line.fbit_time && line.fbit_err)
      next_ferr_cnt = t1_rx_pkg::FERR_HOLD; // [R14]
    else if (line.crc_err && common_control[t1_rx_pkg::CCR_FRAME24])
      next_ferr_cnt = t1_rx_pkg::CRC_HOLD; // [R15]
    else if (ferr_cnt != 2'h0)
      next_ferr_cnt = ferr_cnt - 2'h1;
    next_ferr_out = next_ferr_cnt != 2'h0;
    next_link_sr = link_sr;
    next_link_phase = link_phase;
    next_yel_count = yel_count;
    next_yel = yellow_alarm_out;
    if (common_control[t1_rx_pkg::CCR_FRAME24])
    begin
      // sets must repeat every sixteen link bits once found
      if (line.link_time)
      begin
        next_link_sr = {link_sr[14:0], line.link_bit};
        if (next_link_sr == t1_rx_pkg::YEL_PATTERN &&
            (yel_count == 9'h000 || link_phase == t1_rx_pkg::LINK_LAST))
        begin
          next_link_phase = 4'h0;
          if (yel_count != t1_rx_pkg::YEL_SETS)
            next_yel_count = yel_count + 9'h001;
        end
        else if (link_phase == t1_rx_pkg::LINK_LAST)
        begin
          next_link_phase = 4'h0;
          next_yel_count = 9'h000;
        end
        else
          next_link_phase = link_phase + 4'h1;
      end
      next_yel = next_yel_count == t1_rx_pkg::YEL_SETS; // [R11]
    end
    else if (!common_control[t1_rx_pkg::CCR_YFMT])
    begin
      if (line.bit2_time && line.bit2)
        next_yel_count = 9'h000;
      else if (line.bit2_time && yel_count != t1_rx_pkg::YEL_CHANNELS)
        next_yel_count = yel_count + 9'h001;
      next_yel = next_yel_count == t1_rx_pkg::YEL_CHANNELS; // [R12]
    end
    else if (line.sbit12_time)
      next_yel = line.sbit; // [R12]
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resync_pending <= 1'b1; // [R17]
      common_control <= t1_rx_pkg::REG_RESET; // [R17]
      transmit_control <= t1_rx_pkg::REG_RESET;
      receive_control <= t1_rx_pkg::REG_RESET;
      receive_irq_mask <= t1_rx_pkg::REG_RESET;
      receive_status <= t1_rx_pkg::REG_RESET;
      reg_rdata <= t1_rx_pkg::REG_RESET;
      count_irq <= 1'b0;
      rcr0_prev <= 1'b0;
      loss_of_sync_out <= 1'b0;
      fhist <= 3'h0;
      bipolar_violation_out <= 1'b0;
      zero_run <= 5'h00;
      carrier_loss <= 1'b0;
      ferr_cnt <= 2'h0;
      frame_error_out <= 1'b0;
      link_sr <= 16'h0000;
      link_phase <= 4'h0;
      yel_count <= 9'h000;
      yellow_alarm_out <= 1'b0;
    end
    else
    begin
      resync_pending <= 1'b0;
      common_control <= next_ccr;
      transmit_control <= next_tcr;
      receive_control <= next_rcr;
      receive_irq_mask <= next_mask;
      receive_status <= next_status;
      reg_rdata <= next_rdata;
      count_irq <= next_irq;
      rcr0_prev <= receive_control[t1_rx_pkg::RCR_RESYNC];
      loss_of_sync_out <= next_los;
      fhist <= next_fhist;
      bipolar_violation_out <= next_bpv;
      zero_run <= next_zero_run;
      carrier_loss <= next_cl;
      ferr_cnt <= next_ferr_cnt;
      frame_error_out <= next_ferr_out;
      link_sr <= next_link_sr;
      link_phase <= next_link_phase;
      yel_count <= next_yel_count;
      yellow_alarm_out <= next_yel;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_B8ZS_QUIET: assert property ( // [R3]
    common_control[t1_rx_pkg::CCR_B8ZS] && line.b8zs_word
    |=> !bipolar_violation_out)
    else $error("B8ZS code word flagged as violation");
  AST_ECR_FROZEN: assert property ( // [R7]
    loss_of_sync_out && !ecr_load && !hw_mode
    |=> $stable({oof_count, esf_count}))
    else $error("error counts moved during resync");
  AST_AUTO_RESYNC: assert property ( // [R9]
    !receive_control[t1_rx_pkg::RCR_MANUAL] && oof_event
    |=> loss_of_sync_out)
    else $error("frame loss did not start resync");
  AST_MANUAL_LOW: assert property ( // [R10]
    receive_control[t1_rx_pkg::RCR_MANUAL] && !loss_of_sync_out &&
    !resync_pending && !(receive_control[t1_rx_pkg::RCR_RESYNC] &&
    !rcr0_prev) |=> !loss_of_sync_out)
    else $error("loss of sync rose without manual start");
  AST_LOS_LATCH: assert property ( // [R8]
    loss_of_sync_out |=> receive_status[t1_rx_pkg::ST_LOSS_OF_SYNC_OUT])
    else $error("status did not latch loss of sync");
  AST_FERR_TWO: assert property ( // [R14]
    line.fbit_time && line.fbit_err |=> frame_error_out [*2])
    else $error("frame error not held two bit times");
  AST_CL_SET: assert property ( // [R16]
    line.bit_time && !line.bit_one && zero_run == t1_rx_pkg::CL_LAST
    |=> carrier_loss)
    else $error("carrier loss missed on 32nd zero");
  AST_CL_CLEAR: assert property ( // [R16]
    line.bit_time && line.bit_one |=> !carrier_loss && zero_run == 5'h00)
    else $error("carrier loss not released by a one");
  AST_SBIT_YEL: assert property ( // [R12]
    !common_control[t1_rx_pkg::CCR_FRAME24] &&
    common_control[t1_rx_pkg::CCR_YFMT] && line.sbit12_time
    |=> yellow_alarm_out == $past(line.sbit))
    else $error("S-bit yellow not followed");
  AST_HW_FORCE: assert property ( // [R22]
    hw_mode |=> receive_control == 8'h00 &&
    !common_control[t1_rx_pkg::CCR_YFMT] &&
    transmit_control[t1_rx_pkg::TCR_RBS])
    else $error("hardware mode controls not forced");

  COV_BV_SAT: cover property (bv_ovf ##1 count_irq);
  COV_OOF_RESYNC: cover property (oof_event ##1 loss_of_sync_out
    ##[1:200] !loss_of_sync_out);
  COV_LOOPBACK: cover property (hw_mode &&
    common_control[t1_rx_pkg::CCR_LOOP]);
  COV_YEL24: cover property (yellow_alarm_out &&
    common_control[t1_rx_pkg::CCR_FRAME24]);
endmodule

// ---- line_source.sv ----
`timescale 1ns/1ps
module line_source (
  input wire logic ref_clk,
  output t1_rx_pkg::line_event_type line
);
  initial line = '0;
  // strobes change only after a falling edge, and the line is quiet
  // after each call to send, as a real framer would leave it
  task automatic send(input t1_rx_pkg::line_event_type ev, input int n);
    repeat (n)
    begin
      @(negedge ref_clk);
      line = ev;
    end
    @(negedge ref_clk);
    line = '0;
  endtask
endmodule

// ---- t1_rx_monitor_test.sv ----
`timescale 1ns/1ps
module t1_rx_monitor_test;
  logic ref_clk;
  logic rst_n;
  logic serial_port_select;
  logic [4:0] mode_pins;
  t1_rx_pkg::line_event_type line;
  t1_rx_pkg::line_event_type ev;
  logic reg_wr_en;
  logic reg_rd_en;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] common_control;
  logic [7:0] transmit_control;
  logic loss_of_sync_out;
  logic yellow_alarm_out;
  logic bipolar_violation_out;
  logic frame_error_out;
  logic carrier_loss;
  logic count_irq;
  logic seen;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  t1_rx_monitor dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .serial_port_select(serial_port_select), .mode_pins(mode_pins),
    .line(line), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .common_control(common_control), .transmit_control(transmit_control),
    .loss_of_sync_out(loss_of_sync_out),
    .yellow_alarm_out(yellow_alarm_out),
    .bipolar_violation_out(bipolar_violation_out),
    .frame_error_out(frame_error_out), .carrier_loss(carrier_loss),
    .count_irq(count_irq));
  line_source src (.ref_clk(ref_clk), .line(line));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // the whole sequence needs about one thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pin(input logic v, input logic e);
    chk({7'h00, v}, {7'h00, e});
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata & m, e);
  endtask

  // an irq may trail its event by a couple of edges, so watch a short span
  task automatic irq_chk;
    seen = count_irq;
    repeat (3)
    begin
      @(negedge ref_clk);
      seen = seen | count_irq;
    end
    pin(seen, 1'b1);
  endtask

  task automatic ft_err;
    ev = '0;
    ev.fbit_time = 1'b1;
    ev.fbit_err = 1'b1;
    src.send(ev, 1);
  endtask

  task automatic zeros(input int n, input logic one);
    ev = '0;
    ev.bit_time = 1'b1;
    ev.bit_one = one;
    src.send(ev, n);
  endtask

  task automatic resync_done;
    ev = '0;
    ev.sync_found = 1'b1;
    src.send(ev, 1);
    wait_n(1);
    pin(loss_of_sync_out, 1'b0);
  endtask

  initial
  begin
    rst_n = 1'b0;
    serial_port_select = 1'b1;
    mode_pins = 5'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    wait_n(8);
    rst_n = 1'b1;
    wait_n(6);
    pin(loss_of_sync_out, 1'b1);
    rd(t1_rx_pkg::ADDR_BVC, 8'hff, 8'h00);
    rd(t1_rx_pkg::ADDR_ECR, 8'hff, 8'h00);
    resync_done();
    wr(t1_rx_pkg::ADDR_MASK, 8'hc0);
    wr(t1_rx_pkg::ADDR_CCR, 8'h04);
    wr(t1_rx_pkg::ADDR_BVC, 8'hfd);
    ev = '0;
    ev.bpv = 1'b1;
    src.send(ev, 1);
    pin(bipolar_violation_out, 1'b1);
    wait_n(1);
    pin(bipolar_violation_out, 1'b0);
    ev.b8zs_word = 1'b1;
    src.send(ev, 1);
    pin(bipolar_violation_out, 1'b0);
    rd(t1_rx_pkg::ADDR_BVC, 8'hff, 8'hfe);
    ev.b8zs_word = 1'b0;
    src.send(ev, 1);
    rd(t1_rx_pkg::ADDR_BVC, 8'hff, 8'hff);
    src.send(ev, 1);
    irq_chk();
    rd(t1_rx_pkg::ADDR_BVC, 8'hff, 8'hff);
    wr(t1_rx_pkg::ADDR_ECR, 8'h00);
    ft_err();
    pin(frame_error_out, 1'b1);
    wait_n(1);
    pin(frame_error_out, 1'b1);
    wait_n(1);
    pin(frame_error_out, 1'b0);
    rd(t1_rx_pkg::ADDR_ECR, 8'hff, 8'h01);
    ft_err();
    pin(loss_of_sync_out, 1'b1);
    rd(t1_rx_pkg::ADDR_ECR, 8'hf0, 8'h10);
    wr(t1_rx_pkg::ADDR_ECR, 8'h33);
    ft_err();
    rd(t1_rx_pkg::ADDR_ECR, 8'hff, 8'h33);
    wr(t1_rx_pkg::ADDR_BVC, 8'h10);
    ev = '0;
    ev.bpv = 1'b1;
    src.send(ev, 1);
    rd(t1_rx_pkg::ADDR_BVC, 8'hff, 8'h11);
    resync_done();
    wr(t1_rx_pkg::ADDR_ECR, 8'hff);
    ev = '0;
    ev.fbit_time = 1'b1;
    src.send(ev, 4);
    ft_err();
    irq_chk();
    rd(t1_rx_pkg::ADDR_ECR, 8'hff, 8'hff);
    zeros(31, 1'b0);
    pin(carrier_loss, 1'b0);
    zeros(1, 1'b0);
    pin(carrier_loss, 1'b1);
    wait_n(2);
    pin(loss_of_sync_out, 1'b1);
    rd(t1_rx_pkg::ADDR_STATUS, 8'h11, 8'h11);
    zeros(1, 1'b1);
    pin(carrier_loss, 1'b0);
    resync_done();
    wr(t1_rx_pkg::ADDR_RCR, 8'h02);
    zeros(32, 1'b0);
    wait_n(2);
    pin(loss_of_sync_out, 1'b0);
    zeros(1, 1'b1);
    wr(t1_rx_pkg::ADDR_RCR, 8'h03);
    wait_n(2);
    pin(loss_of_sync_out, 1'b1);
    resync_done();
    wr(t1_rx_pkg::ADDR_RCR, 8'h00);
    ev = '0;
    ev.bit2_time = 1'b1;
    src.send(ev, 255);
    pin(yellow_alarm_out, 1'b0);
    src.send(ev, 1);
    pin(yellow_alarm_out, 1'b1);
    wr(t1_rx_pkg::ADDR_CCR, 8'h08);
    ev = '0;
    ev.sbit12_time = 1'b1;
    src.send(ev, 1);
    pin(yellow_alarm_out, 1'b0);
    ev.sbit = 1'b1;
    src.send(ev, 1);
    pin(yellow_alarm_out, 1'b1);
    wr(t1_rx_pkg::ADDR_CCR, 8'h14);
    ev = '0;
    ev.crc_err = 1'b1;
    src.send(ev, 1);
    pin(frame_error_out, 1'b1);
    wait_n(1);
    pin(frame_error_out, 1'b0);
    ev = '0;
    ev.link_time = 1'b1;
    src.send(ev, 16);
    for (int i = 0; i < 256; i++)
    begin
      if (i == 255)
        pin(yellow_alarm_out, 1'b0);
      ev.link_bit = i[3];
      src.send(ev, 1);
    end
    pin(yellow_alarm_out, 1'b1);
    serial_port_select = 1'b0;
    mode_pins = 5'h07;
    wait_n(8);
    chk(common_control, 8'h10);
    rd(t1_rx_pkg::ADDR_BVC, 8'hff, 8'h00);
    chk(transmit_control, 8'h15);
    mode_pins = 5'h1f;
    wait_n(8);
    chk(common_control, 8'h11);
    rst_n = 1'b0;
    wait_n(1);
    chk(common_control, 8'h00);
    rst_n = 1'b1;
    wait_n(2);
    pin(loss_of_sync_out, 1'b1);
    complete_run();
  end
endmodule
